// ==== include/isra_pkg.sv ====
package isra_pkg;

  // host i/o addresses of the selector and its companion data port
  localparam logic [15:0] SEL_ADDR = 16'h03E0;
  localparam logic [15:0] PORT_ADDR = 16'h03E1;
  localparam int NUM_SOCKETS = 2;

  // selector fields: bit 7 device, bit 6 socket, bits 5:0 register
  localparam int SEL_DEVICE_BIT = 7;
  localparam int SEL_SOCKET_BIT = 6;
  localparam logic [7:0] SOCKET_B_OFFSET = 8'h40;

  // register numbers inside one socket's 64-entry space
  localparam logic [5:0] IDX_CHIP_ID = 6'h00;
  localparam logic [5:0] IDX_SOCK_STATUS = 6'h01;
  localparam logic [5:0] IDX_SOCK_CTRL = 6'h02;
  localparam logic [5:0] IDX_SOCK_SCRATCH = 6'h03;
  localparam logic [5:0] IDX_CHIP_MISC = 6'h1F;

  // bit positions
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_EVENT_BIT = 1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DISABLE_BIT = 1;
  localparam int CTRL_OUTPUT_BIT = 2;
  localparam int CTRL_COMPAT_BIT = 3;
  localparam int MISC_RESTRICTED_BIT = 7;

  // values after reset or power-good cycling
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SCRATCH_RESET = 8'h00;
  localparam logic [7:0] CHIP_MISC_RESET = 8'h80;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [5:0] STATUS_FIXED = 6'h00;
  // chip identity byte: value is arbitrary
  localparam logic [7:0] CHIP_ID_VALUE = 8'h5A;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic byteHighN;
    logic [15:0] data;
  } ioReq_t;

  typedef struct packed {
    logic [15:0] data;
    logic enLo;
    logic enHi;
  } ioRsp_t;

  typedef struct packed {
    logic outPin;
    logic funcOn;
    logic ledOn;
    logic eventFlag;
  } sockPins_t;

endpackage

// ==== hdl/socket_regs.sv ====
module socket_regs
  import isra_pkg::*;
(
  input wire logic clock,
  input wire logic rstN,
  input wire logic powerGoodInput,
  input wire logic we,
  input wire logic [5:0] idx,
  input wire logic [7:0] wrByte,
  input wire logic cardPin,
  output logic [7:0] rdByte,
  output sockPins_t pins
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] scratch;
    logic pinSample;
    logic eventFlag;
    logic primed;
    sockPins_t pins;
  } sockState_t;

  sockState_t s;
  sockState_t next_s;

  // next state; power-good low holds ctrl, scratch and the event flag at their reset values
  always_comb begin
    next_s = s;
    next_s.pinSample = cardPin;
    // the first sample after reset only seeds the detector, so a pin
    // already high at release is not reported as an event
    next_s.primed = 1'b1;
    // a pin change sets the flag; set wins over a same-cycle clear
    next_s.eventFlag = (s.primed && cardPin != s.pinSample) |
      (s.eventFlag &
      !(we && idx == IDX_SOCK_STATUS && wrByte[STAT_EVENT_BIT]));
    if (we && idx == IDX_SOCK_CTRL) begin
      next_s.ctrl = wrByte; // compat bit stored, drives nothing
    end
    if (we && idx == IDX_SOCK_SCRATCH) begin
      next_s.scratch = wrByte;
    end
    if (!powerGoodInput) begin
      next_s.ctrl = CTRL_RESET;
      next_s.scratch = SCRATCH_RESET;
      next_s.eventFlag = 1'b0;
    end
    next_s.pins.outPin = next_s.ctrl[CTRL_OUTPUT_BIT];
    next_s.pins.funcOn = next_s.ctrl[CTRL_ENABLE_BIT];
    next_s.pins.ledOn = !next_s.ctrl[CTRL_DISABLE_BIT];
    next_s.pins.eventFlag = next_s.eventFlag;
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s <= '{ctrl: CTRL_RESET, scratch: SCRATCH_RESET, pinSample: 1'b0,
             eventFlag: 1'b0, primed: 1'b0,
             pins: '{1'b0, 1'b0, 1'b1, 1'b0}};
    end else begin
      s <= next_s;
    end
  end

  // readback; status upper bits are fixed zero and ignore writes
  always_comb begin
    if (idx == IDX_SOCK_STATUS) begin
      rdByte = {STATUS_FIXED, s.eventFlag, s.pinSample};
    end else if (idx == IDX_SOCK_CTRL) begin
      rdByte = s.ctrl;
    end else if (idx == IDX_SOCK_SCRATCH) begin
      rdByte = s.scratch;
    end else begin
      rdByte = UNMAPPED_READ;
    end
  end

  assign pins = s.pins;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  a_fixed_status_bits: assert property (
    idx == IDX_SOCK_STATUS |-> rdByte[7:2] == STATUS_FIXED)
    else $error("status fixed bits changed");
  a_scratch_readback: assert property (
    we && idx == IDX_SOCK_SCRATCH && powerGoodInput |=>
      s.scratch == $past(wrByte))
    else $error("scratch did not store write");
  a_enable_drive: assert property (
    we && idx == IDX_SOCK_CTRL && powerGoodInput |=>
      pins.funcOn == $past(wrByte[CTRL_ENABLE_BIT]))
    else $error("enable output wrong");
  a_disable_drive: assert property (
    we && idx == IDX_SOCK_CTRL && powerGoodInput |=>
      pins.ledOn == !$past(wrByte[CTRL_DISABLE_BIT]))
    else $error("disable bit did not turn function off");
  a_input_sample: assert property (
    $past(rstN) |-> s.pinSample == $past(cardPin))
    else $error("input pin not sampled");
  a_status_not_set: assert property (
    $rose(s.eventFlag) |-> $past(cardPin) != $past(s.pinSample))
    else $error("status set without event");
  a_power_good_load: assert property (
    !powerGoodInput |=> s.ctrl == CTRL_RESET && !s.eventFlag)
    else $error("power-good did not reload");

  c_event_cleared: cover property (s.eventFlag ##1 !s.eventFlag);
  c_ctrl_written: cover property (we && idx == IDX_SOCK_CTRL);

endmodule

// ==== hdl/indexed_socket_register_access.sv ====
// Contract
// - selector sits at 03E0h, data port at 03E1h; only path inside.
// - a data port access reaches the register the selector chooses.
// - socket B copy decodes at socket A selector value plus 40h.
// - chip-wide registers are single; socket registers exist once per socket.
// - fixed bits read as constants and ignore host writes.
// - scratchpad bits store and return what the host wrote.
// - compatibility bits are stored but steer nothing.
// - an enable bit turns its function on when 1.
// - a disable bit turns its function off when 1.
// - input bits show the sampled pin; output bits drive their pin.
// - status bits are set only by events; host can only clear them.
// - read/write bits reload their reset value when power-good cycles.
// - read-only bits show their reset value after power-good cycles.
// - selector bits 5:0 register, bit 6 socket, bit 7 device.
// - selector reads back only on device 0; device 1 gives high byte.
module indexed_socket_register_access
  import isra_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic powerGoodInput,
  input wire logic deviceStrap,
  input wire ioReq_t ioReq,
  input wire logic [NUM_SOCKETS-1:0] cardPin,
  output ioRsp_t ioRsp,
  output sockPins_t [NUM_SOCKETS-1:0] sockPins
);

  typedef struct packed {
    ioRsp_t rsp;
    logic [7:0] index;
    logic [7:0] chipMisc;
    logic devId;
    logic strapTaken;
  } topState_t;

  topState_t s;
  topState_t next_s;
  logic rstMeta;
  logic rstN;
  logic [7:0] sockRd [NUM_SOCKETS];
  logic [NUM_SOCKETS-1:0] sockWe;
  logic selHit;
  logic portHit;
  logic wordAcc;
  logic portWr;
  logic portRd;
  logic selRd;
  logic devMatch;
  logic chipWe;
  logic [7:0] newIndex;
  logic [7:0] portByte;
  logic [7:0] regByte;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // address decode; a word at the even address covers both ports
  always_comb begin
    selHit = ioReq.addr == SEL_ADDR;
    portHit = ioReq.addr == PORT_ADDR;
    wordAcc = selHit && !ioReq.byteHighN;
    // selector write lands before the port half uses it
    newIndex = (ioReq.wr && selHit) ? ioReq.data[7:0] : s.index;
    portWr = ioReq.wr && (portHit || wordAcc);
    // odd byte sits on the high lane when the high enable is active
    if (portHit && ioReq.byteHighN) begin
      portByte = ioReq.data[7:0];
    end else begin
      portByte = ioReq.data[15:8];
    end
    devMatch = newIndex[SEL_DEVICE_BIT] == s.devId;
    // chip-wide registers live only at the socket A numbers
    chipWe = portWr && devMatch && !newIndex[SEL_SOCKET_BIT] &&
      newIndex[5:0] == IDX_CHIP_MISC;
    portRd = ioReq.rd && (portHit || wordAcc) &&
      s.index[SEL_DEVICE_BIT] == s.devId;
    selRd = ioReq.rd && selHit && !s.devId;
  end

  // per-socket write strobes, bit 6 picks the copy
  generate
    for (genvar k = 0; k < NUM_SOCKETS; k++) begin : g_sock
      assign sockWe[k] = portWr && devMatch &&
        newIndex[SEL_SOCKET_BIT] == 1'(k);
      socket_regs u_sock (
        .clock(clock),
        .rstN(rstN),
        .powerGoodInput(powerGoodInput),
        .we(sockWe[k]),
        .idx(newIndex[5:0]),
        .wrByte(portByte),
        .cardPin(cardPin[k]),
        .rdByte(sockRd[k]),
        .pins(sockPins[k])
      );
    end
  endgenerate

  // byte seen through the data port for the current selector
  always_comb begin
    if (!s.index[SEL_SOCKET_BIT] && s.index[5:0] == IDX_CHIP_ID) begin
      regByte = CHIP_ID_VALUE;
    end else if (!s.index[SEL_SOCKET_BIT] &&
                 s.index[5:0] == IDX_CHIP_MISC) begin
      regByte = s.chipMisc;
    end else begin
      regByte = sockRd[s.index[SEL_SOCKET_BIT]];
    end
  end

  // next state of the host-facing registers
  always_comb begin
    next_s = s;
    if (!s.strapTaken) begin
      next_s.devId = deviceStrap; // strap caught once after release
      next_s.strapTaken = 1'b1;
    end
    next_s.index = newIndex;
    if (chipWe) begin
      // restricted bit is plain storage; host keeps to its one value
      next_s.chipMisc = portByte;
    end
    next_s.rsp.enLo = selRd || (portRd && portHit && ioReq.byteHighN);
    next_s.rsp.enHi = portRd && !(portHit && ioReq.byteHighN);
    next_s.rsp.data = 16'h0000;
    if (selRd) begin
      next_s.rsp.data[7:0] = s.index;
    end else if (next_s.rsp.enLo) begin
      next_s.rsp.data[7:0] = regByte;
    end
    if (next_s.rsp.enHi) begin
      next_s.rsp.data[15:8] = regByte;
    end
    if (!powerGoodInput) begin
      next_s.index = SEL_RESET;
      next_s.chipMisc = CHIP_MISC_RESET;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s <= '{rsp: '{16'h0000, 1'b0, 1'b0}, index: SEL_RESET,
             chipMisc: CHIP_MISC_RESET, devId: 1'b0, strapTaken: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign ioRsp = s.rsp;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  a_selector_write: assert property (
    ioReq.wr && ioReq.addr == SEL_ADDR && powerGoodInput |=>
      s.index == $past(ioReq.data[7:0]))
    else $error("selector write lost");
  a_word_order: assert property (
    ioReq.wr && wordAcc && ioReq.data[SEL_DEVICE_BIT] == s.devId &&
      powerGoodInput |->
      sockWe[ioReq.data[SEL_SOCKET_BIT]] && newIndex == ioReq.data[7:0])
    else $error("word write used old selector");
  a_read_answer: assert property (
    portRd |=> (ioRsp.enLo || ioRsp.enHi) ##1 !(ioRsp.enLo || ioRsp.enHi)
      || $past(ioReq.rd))
    else $error("data port read not answered for one cycle");
  a_socket_b_read: assert property (
    portRd && !portHit &&
      s.index[SEL_SOCKET_BIT] |=> ioRsp.data[15:8] == $past(sockRd[1]))
    else $error("socket B copy not selected");
  a_chip_id_fixed: assert property (
    s.index == SEL_RESET |-> regByte == CHIP_ID_VALUE)
    else $error("chip id not constant");
  a_device1_silent: assert property (
    s.devId && ioReq.rd && selHit |=> !ioRsp.enLo)
    else $error("device 1 drove selector readback");
  a_power_good_index: assert property (
    !powerGoodInput |=> s.index == SEL_RESET &&
      s.chipMisc == CHIP_MISC_RESET)
    else $error("power-good did not reload selector");
  // socket B numbers never reach the single chip-wide copy
  a_chip_shared: assert property (
    portWr && newIndex[SEL_SOCKET_BIT] && powerGoodInput |=>
      $stable(s.chipMisc))
    else $error("chip-wide write misrouted");
  a_chip_misc_store: assert property (
    chipWe && powerGoodInput |=> s.chipMisc == $past(portByte))
    else $error("chip-wide register lost a write");
  a_foreign_addr_quiet: assert property (
    ioReq.rd && !selHit && !portHit |=> !ioRsp.enLo && !ioRsp.enHi)
    else $error("answered a foreign address");
  // a read for the other device must leave both lanes to that device
  a_other_device_quiet: assert property (
    ioReq.rd && portHit && s.index[SEL_DEVICE_BIT] != s.devId |=>
      !ioRsp.enLo && !ioRsp.enHi)
    else $error("data port answered for other device");
  a_index_readback: assert property (
    selRd |=> ioRsp.data[7:0] == $past(s.index))
    else $error("selector readback wrong");
  a_word_read_lanes: assert property (
    portRd && wordAcc |=> ioRsp.enHi && ioRsp.data[15:8] == $past(regByte))
    else $error("word read missed the high lane");
  // the device id must not move once software has started using it
  a_strap_once: assert property (
    s.strapTaken |=> $stable(s.devId))
    else $error("device id changed after release");

  c_word_write: cover property (ioReq.wr && wordAcc);
  c_socket_b_write: cover property (sockWe[1]);
  c_selector_read: cover property (selRd ##1 ioRsp.enLo);

endmodule

// ==== sim/isa_host_model.sv ====
module isa_host_model
  import isra_pkg::*;
(
  input wire logic clock,
  output ioReq_t ioReq,
  input wire ioRsp_t ioRsp
);
  timeunit 1ns;
  timeprecision 100ps;

  initial ioReq = '0;

  // one strobe cycle; released lines show inverted values so that a
  // stale address or data word never looks like a held request
  task automatic cyc(input logic [15:0] a, input logic r, input logic w,
      input logic b, input logic [15:0] d, output ioRsp_t rsp);
    @(posedge clock);
    #1;
    ioReq = '{addr: a, rd: r, wr: w, byteHighN: b, data: d};
    @(posedge clock);
    #1;
    rsp = ioRsp;
    ioReq = '{addr: ~a, rd: 1'b0, wr: 1'b0, byteHighN: ~b, data: ~d};
  endtask
endmodule

// ==== sim/indexed_socket_register_access_tb_top.sv ====
module indexed_socket_register_access_tb_top;
  import isra_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0] idx;
    logic wrOn;
    logic [7:0] wv;
    logic [7:0] exp;
  } row_t;

  logic clock;
  logic arst_n;
  logic powerGoodInput;
  logic deviceStrap;
  logic [1:0] cardPin;
  ioReq_t ioReq;
  ioRsp_t ioRsp;
  ioRsp_t rsp;
  sockPins_t [NUM_SOCKETS-1:0] sockPins;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;

  // writes to read-only places are refused on purpose
  localparam row_t ROWS [9] = '{
    '{8'h03, 1'b1, 8'hA5, 8'hA5},
    '{8'h43, 1'b1, 8'h3C, 8'h3C},
    '{8'h03, 1'b0, 8'h00, 8'hA5},
    '{8'h00, 1'b1, 8'hFF, CHIP_ID_VALUE},
    '{8'h01, 1'b1, 8'hFF, 8'h00},
    '{8'h1F, 1'b1, 8'h81, 8'h81},
    '{8'h5F, 1'b1, 8'h00, UNMAPPED_READ},
    '{8'h1F, 1'b0, 8'h00, 8'h81},
    '{8'h20, 1'b0, 8'h00, UNMAPPED_READ}
  };

  isa_host_model host (.clock(clock), .ioReq(ioReq), .ioRsp(ioRsp));

  indexed_socket_register_access dut (
    .clock(clock),
    .arst_n(arst_n),
    .powerGoodInput(powerGoodInput),
    .deviceStrap(deviceStrap),
    .ioReq(ioReq),
    .cardPin(cardPin),
    .ioRsp(ioRsp),
    .sockPins(sockPins)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic wrap_up;
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under 300 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  // word write: selector in the low byte, register value in the high
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    host.cyc(SEL_ADDR, 1'b0, 1'b1, 1'b0, {v, idx}, rsp);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    host.cyc(SEL_ADDR, 1'b0, 1'b1, 1'b1, {8'h00, idx}, rsp);
    host.cyc(PORT_ADDR, 1'b1, 1'b0, 1'b1, 16'h0000, rsp);
    chk({7'h00, rsp.enLo}, 8'h01);
    chk(rsp.data[7:0], exp);
  endtask

  initial begin
    arst_n = 1'b0;
    powerGoodInput = 1'b1;
    deviceStrap = 1'b0;
    cardPin = 2'b00;
    repeat (10) @(posedge clock);
    #1;
    chk({7'h00, sockPins[0].ledOn}, 8'h01);
    chk(ioRsp.data[7:0], 8'h00);
    arst_n = 1'b1;
    repeat (4) @(posedge clock);
    rd(8'h1F, CHIP_MISC_RESET);
    foreach (ROWS[i]) begin
      if (ROWS[i].wrOn) begin
        wr(ROWS[i].idx, ROWS[i].wv);
      end
      rd(ROWS[i].idx, ROWS[i].exp);
    end
    // pins of socket B follow its control byte, socket A stays idle
    wr(8'h42, 8'h07);
    tick();
    chk({sockPins[1], sockPins[0]}, 8'hC2);
    wr(8'h42, 8'h08);
    tick();
    chk({sockPins[1], sockPins[0]}, 8'h22);
    // word read at the selector: selector low, chosen register high
    host.cyc(SEL_ADDR, 1'b1, 1'b0, 1'b0, 16'h0000, rsp);
    chk({6'h00, rsp.enLo, rsp.enHi}, 8'h03);
    chk(rsp.data[7:0], 8'h42);
    chk(rsp.data[15:8], 8'h08);
    // pin change raises the event, a write of 1 clears it
    cardPin = 2'b10;
    repeat (3) tick();
    chk({7'h00, sockPins[1].eventFlag}, 8'h01);
    rd(8'h41, 8'h03);
    wr(8'h41, 8'h02);
    rd(8'h41, 8'h01);
    // other device selected: the data port must stay silent
    host.cyc(SEL_ADDR, 1'b0, 1'b1, 1'b1, 16'h0083, rsp);
    host.cyc(PORT_ADDR, 1'b0, 1'b1, 1'b1, 16'h00FF, rsp);
    host.cyc(PORT_ADDR, 1'b1, 1'b0, 1'b1, 16'h0000, rsp);
    chk({6'h00, rsp.enLo, rsp.enHi}, 8'h00);
    rd(8'h03, 8'hA5);
    host.cyc(16'h03E2, 1'b1, 1'b0, 1'b1, 16'h0000, rsp);
    chk({6'h00, rsp.enLo, rsp.enHi}, 8'h00);
    // power-good cycling reloads defaults, fixed id survives
    wr(8'h02, 8'h07);
    powerGoodInput = 1'b0;
    repeat (2) tick();
    powerGoodInput = 1'b1;
    rd(8'h03, SCRATCH_RESET);
    rd(8'h1F, CHIP_MISC_RESET);
    rd(8'h02, CTRL_RESET);
    chk({6'h00, sockPins[0].funcOn, sockPins[0].ledOn}, 8'h01);
    rd(8'h00, CHIP_ID_VALUE);
    // second reset with the strap high; socket B pin stays high across it
    wr(8'h42, 8'h07);
    arst_n = 1'b0;
    deviceStrap = 1'b1;
    tick();
    chk({sockPins[1], sockPins[0]}, 8'h22);
    arst_n = 1'b1;
    repeat (4) tick();
    chk({7'h00, sockPins[1].eventFlag}, 8'h00);
    // device 1: selector silent on word reads, data on the high lane
    wr(8'h83, 8'h5C);
    host.cyc(SEL_ADDR, 1'b1, 1'b0, 1'b0, 16'h0000, rsp);
    chk({6'h00, rsp.enLo, rsp.enHi}, 8'h01);
    chk(rsp.data[15:8], 8'h5C);
    chk(rsp.data[7:0], 8'h00);
    wrap_up();
  end
endmodule
